//--- rtl/spd_top.sv
/*
 * serial packet delimiter: cuts the received serial character stream into
 * packets for the network side and rebuilds packet boundaries on transmit.
 * assumes a uart core on the same clock that reports the marker position,
 * and an upstream transmit buffer that reports its fill level.
 */
// Our own choices: the register addresses and the Wishbone slave port.
// Behaviour
// - delimiting mode per port: none, idle (streams like none), string send, string cut, marker bit
// - string modes put no upper bound on packet length
// - terminator of one to eight characters, matched only as exact consecutive run
// - string send forwards the terminator characters, the last one carrying the packet end marker
// - string cut drops the terminator and forwards only the packet end marker
// - in send mode a received packet end adds nothing to serial output
// - in cut mode a received packet end appends the local terminator
// - each end uses local settings, so terminators convert between ends
// - marker mode flags the first character of each transmitted packet
// - marked character carries a set marker bit before the stop bit
// - parity is not checked while marker mode is active
// - received marker is a packet start, not a framing error
// - marker mode ends the previous packet only when a marked character arrives
// - the marked character stays ordinary payload, first byte of the packet
// - with seven-bit characters the marker follows the seventh data bit
// - transmit starts once threshold characters are buffered, even without end
// - string modes take a trailing count of characters after the match
`timescale 1ns/1ns
module spd_top
(
    input  wire logic               core_clk_i,
    input  wire logic               reset_i,
    input  wire logic               ce_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [31:0]        wb_dat_i,
    input  wire logic [3:0]         wb_sel_i,
    output      logic [31:0]        wb_dat_o,
    output      logic               wb_ack_o,
    input  wire logic               rx_valid_i,
    input  wire spd_pkg::spd_char_t rx_char_i,
    output      logic               rx_ready_o,
    output      logic               net_out_valid_o,
    output      spd_pkg::spd_word_t net_out_word_o,
    input  wire logic               net_out_ready_i,
    input  wire logic               net_in_valid_i,
    input  wire spd_pkg::spd_word_t net_in_word_i,
    output      logic               net_in_ready_o,
    input  wire logic [9:0]         net_in_level_i,
    input  wire logic               net_in_end_held_i,
    output      logic               tx_valid_o,
    output      spd_pkg::spd_char_t tx_char_o,
    input  wire logic               tx_ready_i,
    output      logic               cfg_marker_mode_o,
    output      logic               cfg_seven_bit_o,
    output      logic               cfg_parity_off_o
);
    import spd_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] mask_char(input logic [7:0] c, input logic seven);
        mask_char = seven ? (c & SEVEN_MASK) : c;
    endfunction

    function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
        int i;
        wb_merge = old;
        for (i = 0; i < 4; i++)
        begin
            if (sel[i])
                wb_merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    // last tlen characters (held history plus the new one) against the terminator
    function automatic logic term_hit(input logic [7:0][7:0] hist,
                                      input logic [3:0]      hcnt,
                                      input logic [7:0]      c,
                                      input logic [7:0][7:0] term,
                                      input logic [3:0]      tlen,
                                      input logic            seven);
        int k;
        term_hit = (hcnt >= tlen - TERM_LEN_MIN);
        if (mask_char(c, seven) != mask_char(term[int'(tlen) - 1], seven))
            term_hit = 1'b0;
        for (k = 1; k < 8; k++)
        begin
            if (k < int'(tlen))
            begin
                if (hist[k - 1] != mask_char(term[int'(tlen) - 1 - k], seven))
                    term_hit = 1'b0;
            end
        end
    endfunction

    spd_state_t  q;
    spd_state_t  d;
    spd_ctrl_t   rd_ctrl;
    spd_format_t rd_fmt;
    spd_status_t rd_stat;
    spd_ctrl_t   wr_ctrl;
    spd_format_t wr_fmt;
    spd_word_t   push_word;
    logic        push;
    logic        pop;
    logic        is_string;
    logic        hit;
    logic        fifo_ok;
    logic        split_end;
    logic        rx_fire;
    logic        released;
    logic        out_free;
    logic        net_fire;
    logic        wb_go;
    logic        tx_load;
    logic [7:0]  cdat;
    logic [31:0] wr_val;
    logic [7:0][7:0] hist_new;

    // ************************************************************
    // handshakes
    // ************************************************************
    assign is_string = (q.mode == MODE_SEND) || (q.mode == MODE_CUT);
    assign cdat      = mask_char(rx_char_i.data, q.seven);
    assign hit       = is_string && (q.tleft == 8'h00) &&
                       term_hit(q.hist, q.hcnt, rx_char_i.data, q.term, q.tlen, q.seven);
    assign fifo_ok   = q.fcnt != FIFO_DEPTH;
    // a marked character first closes the open packet, one cycle ahead
    assign split_end = (q.mode == MODE_MARK) && rx_valid_i && rx_char_i.mark &&
                       q.pkt_open;
    assign rx_ready_o = fifo_ok && !split_end;
    assign rx_fire    = rx_valid_i && rx_ready_o;
    assign pop        = net_out_ready_i && (q.fcnt != 2'h0);
    assign released   = (net_in_level_i >= q.thresh) || net_in_end_held_i;
    assign out_free   = !q.txv || tx_ready_i;
    assign net_in_ready_o = out_free && released && (q.txs == TX_NORM);
    assign net_fire   = net_in_valid_i && net_in_ready_o;
    assign wb_go      = wb_cyc_i && wb_stb_i && !q.ack;
    assign wb_ack_o          = q.ack;
    assign wb_dat_o          = q.rdat;
    assign net_out_valid_o   = q.fcnt != 2'h0;
    assign net_out_word_o    = q.fifo[q.frd];
    assign tx_valid_o        = q.txv;
    assign tx_char_o         = q.txc;
    assign cfg_marker_mode_o = q.mode == MODE_MARK;
    assign cfg_seven_bit_o   = q.seven;
    assign cfg_parity_off_o  = q.mode == MODE_MARK;
    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        d         = q;
        push      = 1'b0;
        push_word = '0;
        tx_load   = 1'b0;
        hist_new  = {q.hist[6:0], cdat};

        rd_ctrl = '{mode: q.mode, seven: q.seven, default: '0};
        rd_fmt  = '{len: q.tlen, trail: q.trail, default: '0};
        rd_stat = '{pkts: q.pkts, fill: q.fcnt, held: q.hcnt, inserting: q.txs == TX_INS,
                    pkt_open: q.pkt_open, frame_err: q.frm_err, default: '0};
        // register bus: one wait state, unmapped reads zero
        d.ack = wb_go;
        unique case (wb_adr_i)
            ADR_CTRL:    wr_val = rd_ctrl;
            ADR_FORMAT:  wr_val = rd_fmt;
            ADR_TERM_LO: wr_val = q.term[3:0];
            ADR_TERM_HI: wr_val = q.term[7:4];
            ADR_THRESH:  wr_val = {22'h0, q.thresh};
            ADR_STATUS:  wr_val = rd_stat;
            default:     wr_val = 32'h0;
        endcase
        if (wb_go)
            d.rdat = wb_we_i ? 32'h0 : wr_val;
        wr_ctrl = spd_ctrl_t'(wb_merge(wr_val, wb_dat_i, wb_sel_i));
        wr_fmt  = spd_format_t'(wb_merge(wr_val, wb_dat_i, wb_sel_i));
        if (wb_go && wb_we_i)
        begin
            unique case (wb_adr_i)
                ADR_CTRL:
                begin
                    d.seven = wr_ctrl.seven;
                    // unknown codes fall back to plain streaming
                    d.mode  = (wr_ctrl.mode > MODE_MARK) ? MODE_NONE : wr_ctrl.mode;
                end
                ADR_FORMAT:
                begin
                    d.trail = wr_fmt.trail;
                    d.tlen  = (wr_fmt.len < TERM_LEN_MIN) ? TERM_LEN_MIN :
                              (wr_fmt.len > TERM_LEN_MAX) ? TERM_LEN_MAX : wr_fmt.len;
                end
                ADR_TERM_LO: d.term[3:0] = wb_merge(wr_val, wb_dat_i, wb_sel_i);
                ADR_TERM_HI: d.term[7:4] = wb_merge(wr_val, wb_dat_i, wb_sel_i);
                ADR_THRESH:
                begin
                    wr_val   = wb_merge(wr_val, wb_dat_i, wb_sel_i);
                    d.thresh = (wr_val[9:0] > THRESH_MAX) ? THRESH_MAX : wr_val[9:0];
                end
                ADR_STATUS:
                begin
                    wr_val = wb_merge(32'h0, wb_dat_i, wb_sel_i);
                    if (wr_val[0])
                        d.frm_err = 1'b0;
                end
                default: ;
            endcase
        end

        // receive side: serial characters into packets
        if (split_end && fifo_ok)
        begin
            push           = 1'b1;
            push_word.last = 1'b1;
            d.pkt_open     = 1'b0;
            d.pkts         = q.pkts + 16'h0001;
        end
        else if (rx_fire)
        begin
            d.pkt_open         = 1'b1;
            push_word.data     = cdat;
            push_word.has_data = 1'b1;
            if (rx_char_i.mark && (q.mode != MODE_MARK))
                d.frm_err = 1'b1;
            if (!is_string)
                push = 1'b1;
            else if (q.tleft != 8'h00)
            begin
                push           = 1'b1;
                push_word.last = q.tleft == 8'h01;
                d.tleft        = q.tleft - 8'h01;
                if (q.tleft == 8'h01)
                begin
                    d.pkt_open = 1'b0;
                    d.pkts     = q.pkts + 16'h0001;
                end
            end
            else if (hit)
            begin
                d.hcnt  = 4'h0;
                d.tleft = q.trail;
                if (q.mode == MODE_SEND)
                begin
                    push           = 1'b1;
                    push_word.last = q.trail == 8'h00;
                end
                else if (q.trail == 8'h00)
                begin
                    push               = 1'b1;
                    push_word.has_data = 1'b0;
                    push_word.data     = 8'h00;
                    push_word.last     = 1'b1;
                end
                if (q.trail == 8'h00)
                begin
                    d.pkt_open = 1'b0;
                    d.pkts     = q.pkts + 16'h0001;
                end
            end
            else
            begin
                d.hist = hist_new;
                if (q.mode == MODE_SEND)
                begin
                    push   = 1'b1;
                    d.hcnt = (q.hcnt == HIST_MAX) ? HIST_MAX : q.hcnt + 4'h1;
                end
                else if (q.hcnt + TERM_LEN_MIN >= q.tlen)
                begin
                    // oldest held character can no longer start a match
                    push           = 1'b1;
                    push_word.data = hist_new[q.hcnt];
                end
                else
                    d.hcnt = q.hcnt + 4'h1;
            end
        end

        // two-entry buffer toward the network
        if (push)
            d.fifo[q.frd ^ q.fcnt[0]] = push_word;
        if (pop)
            d.frd = ~q.frd;
        d.fcnt = q.fcnt + {1'b0, push} - {1'b0, pop};

        // transmit side: network words onto the serial line
        if (q.txv && tx_ready_i)
            d.txv = 1'b0;
        unique case (q.txs)
            TX_NORM:
            begin
                if (net_fire)
                begin
                    if (net_in_word_i.has_data)
                    begin
                        tx_load     = 1'b1;
                        d.txv       = 1'b1;
                        d.txc.data  = mask_char(net_in_word_i.data, q.seven);
                        d.txc.mark  = (q.mode == MODE_MARK) && q.first;
                        d.first     = 1'b0;
                    end
                    if (net_in_word_i.last && (q.mode == MODE_CUT))
                    begin
                        d.txs  = TX_INS;
                        d.tidx = 3'h0;
                    end
                    else if (net_in_word_i.last)
                        d.first = 1'b1;
                end
            end
            TX_INS:
            begin
                if (out_free)
                begin
                    tx_load    = 1'b1;
                    d.txv      = 1'b1;
                    d.txc.data = mask_char(q.term[q.tidx], q.seven);
                    d.txc.mark = (q.mode == MODE_MARK) && q.first;
                    d.first    = 1'b0;
                    d.tidx     = q.tidx + 3'h1;
                    if ({1'b0, q.tidx} == q.tlen - TERM_LEN_MIN)
                    begin
                        d.txs   = TX_NORM;
                        d.first = 1'b1;
                    end
                end
            end
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            q        <= '0;
            q.mode   <= MODE_NONE;
            q.tlen   <= TERM_LEN_MIN;
            q.term   <= TERM_RST;
            q.thresh <= THRESH_MAX;
            q.txs    <= TX_NORM;
            q.first  <= 1'b1;
        end
        else if (ce_i)
            q <= d;
    end
    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    AST_TLEN_RANGE: assert property (q.tlen >= TERM_LEN_MIN && q.tlen <= TERM_LEN_MAX)
        else $error("terminator length out of range");
    AST_SEND_FORWARD: assert property (rx_fire && hit && q.mode == MODE_SEND &&
        q.trail == 8'h00 |-> push && push_word.last && push_word.has_data &&
        push_word.data == cdat)
        else $error("send mode did not forward terminator with end");
    AST_CUT_DROP: assert property (rx_fire && hit && q.mode == MODE_CUT &&
        q.trail == 8'h00 |-> push && push_word.last && !push_word.has_data)
        else $error("cut mode leaked terminator");
    AST_SEND_NO_APPEND: assert property (ce_i && net_fire && net_in_word_i.last &&
        q.mode == MODE_SEND |=> q.txs == TX_NORM)
        else $error("send mode appended characters");
    AST_CUT_APPEND: assert property (ce_i && net_fire && net_in_word_i.last &&
        q.mode == MODE_CUT |=> q.txs == TX_INS && q.tidx == 3'h0)
        else $error("cut mode did not start terminator insert");
    AST_MARK_FIRST: assert property (ce_i && tx_load && q.mode == MODE_MARK |=>
        q.txc.mark == $past(q.first) && q.txv)
        else $error("marker bit not on first character");
    AST_DEFER_END: assert property (q.mode == MODE_MARK && push && push_word.last |->
        rx_valid_i && rx_char_i.mark && q.pkt_open && !rx_ready_o)
        else $error("marker mode ended packet without marked character");
    AST_NO_FRAME_ERR: assert property (ce_i && rx_fire && rx_char_i.mark &&
        q.mode == MODE_MARK && !q.frm_err |=> !q.frm_err)
        else $error("marker flagged as framing error");
    AST_THRESH_HOLD: assert property (ce_i && !q.txv && q.txs == TX_NORM &&
        !net_in_end_held_i && net_in_level_i < q.thresh |=> !q.txv)
        else $error("transmit started below threshold");
    AST_TRAIL_PASS: assert property (rx_fire && is_string && q.tleft != 8'h00 |->
        push && push_word.has_data && push_word.last == (q.tleft == 8'h01))
        else $error("trailing character mishandled");
    AST_INSERT_LEN: assert property (ce_i && q.txs == TX_INS && out_free &&
        {1'b0, q.tidx} == q.tlen - TERM_LEN_MIN |=> q.txs == TX_NORM && q.first)
        else $error("terminator insert length wrong");
    AST_FIFO_BOUND: assert property (q.fcnt <= FIFO_DEPTH)
        else $error("buffer overfilled");
    COV_SEND_MATCH: cover property (rx_fire && hit && q.mode == MODE_SEND);
    COV_CUT_INSERT: cover property (q.txs == TX_INS ##1 q.txs == TX_NORM);
    COV_MARK_SPLIT: cover property (split_end && fifo_ok);
    COV_FIFO_FULL:  cover property (q.fcnt == FIFO_DEPTH && !net_out_ready_i);
endmodule // spd_top

//--- rtl/spd_pkg.sv
/*
 * constants, layouts and state type of the serial packet delimiter.
 * assumes a single core clock and word-aligned wishbone register offsets.
 */
package spd_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADR_CTRL    = 8'h00;
    localparam logic [7:0] ADR_FORMAT  = 8'h04;
    localparam logic [7:0] ADR_TERM_LO = 8'h08;
    localparam logic [7:0] ADR_TERM_HI = 8'h0C;
    localparam logic [7:0] ADR_THRESH  = 8'h10;
    localparam logic [7:0] ADR_STATUS  = 8'h14;

    // ************************************************************
    // limits and reset values
    // ************************************************************
    localparam logic [3:0]  TERM_LEN_MIN = 4'h1;
    localparam logic [3:0]  TERM_LEN_MAX = 4'h8;
    localparam logic [3:0]  HIST_MAX     = 4'h7;
    localparam logic [63:0] TERM_RST     = 64'h0000_0000_0000_000A;
    localparam logic [9:0]  THRESH_MAX   = 10'h3FC;
    localparam logic [7:0]  SEVEN_MASK   = 8'h7F;
    localparam logic [1:0]  FIFO_DEPTH   = 2'h2;

    typedef enum logic [2:0] {
        MODE_NONE = 3'h0,
        MODE_IDLE = 3'h1,
        MODE_SEND = 3'h2,
        MODE_CUT  = 3'h3,
        MODE_MARK = 3'h4
    } spd_mode_t;

    typedef enum logic [1:0] {
        TX_NORM = 2'b01,
        TX_INS  = 2'b10
    } spd_tx_state_t;

    // ************************************************************
    // carriers and register layouts
    // ************************************************************
    typedef struct packed {
        logic       last;
        logic       has_data;
        logic [7:0] data;
    } spd_word_t;

    typedef struct packed {
        logic       mark;
        logic [7:0] data;
    } spd_char_t;

    typedef struct packed {
        logic [26:0] rsv;
        logic        seven;
        logic        rsv1;
        spd_mode_t   mode;
    } spd_ctrl_t;

    typedef struct packed {
        logic [15:0] rsv;
        logic [7:0]  trail;
        logic [3:0]  rsv1;
        logic [3:0]  len;
    } spd_format_t;

    typedef struct packed {
        logic [15:0] pkts;
        logic [5:0]  rsv;
        logic [1:0]  fill;
        logic [3:0]  held;
        logic        rsv1;
        logic        inserting;
        logic        pkt_open;
        logic        frame_err;
    } spd_status_t;

    typedef struct packed {
        logic                ack;
        logic [31:0]         rdat;
        spd_mode_t           mode;
        logic                seven;
        logic [3:0]          tlen;
        logic [7:0]          trail;
        logic [7:0][7:0]     term;
        logic [9:0]          thresh;
        logic [7:0][7:0]     hist;
        logic [3:0]          hcnt;
        logic [7:0]          tleft;
        logic                pkt_open;
        logic                frm_err;
        logic [15:0]         pkts;
        spd_word_t [1:0]     fifo;
        logic [1:0]          fcnt;
        logic                frd;
        spd_tx_state_t       txs;
        logic [2:0]          tidx;
        logic                first;
        logic                txv;
        spd_char_t           txc;
    } spd_state_t;

endpackage

//--- testbench/spd_ser_model.sv
/*
 * serial transmitter stand-in: takes tx chars, stalling when told to.
 * assumes the bench clock and reset; keeps what it took in a queue.
 */
`timescale 1ns/1ns
module spd_ser_model
(
    input  wire logic               core_clk_i,
    input  wire logic               reset_i,
    input  wire logic               stall_i,
    input  wire logic               tx_valid_i,
    input  wire spd_pkg::spd_char_t tx_char_i,
    output      logic               tx_ready_o
);
    import spd_pkg::*;
    spd_char_t got[$];
    always @(posedge core_clk_i or posedge reset_i)
        if (reset_i)
            tx_ready_o <= 1'b0;
        else
        begin
            if (tx_valid_i && tx_ready_o)
                got.push_back(tx_char_i);
            tx_ready_o <= !stall_i;
        end
endmodule // spd_ser_model

//--- testbench/tb.sv
/*
 * bench for the serial packet delimiter: registers, rx and tx paths.
 * assumes spd_pkg and the serial model; stalls from a fixed lfsr.
 */
`timescale 1ns/1ns
module tb;
    import spd_pkg::*;
    logic core_clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = 4'hF;
    logic rx_valid_i = 1'b0, rx_ready_o, net_out_valid_o, hold = 1'b0;
    logic net_out_ready_i = 1'b0, net_in_valid_i = 1'b0, net_in_ready_o;
    logic tx_valid_o, tx_ready_i, stall = 1'b0, net_in_end_held_i = 1'b1;
    logic cfg_marker_mode_o, cfg_seven_bit_o, cfg_parity_off_o;
    logic [9:0] net_in_level_i = 10'h000;
    logic [16:0] lf = 17'h1733A;
    spd_char_t rx_char_i = '0, tx_char_o;
    spd_word_t net_out_word_o, net_in_word_i = '0, oq[$], ex[$];
    spd_char_t tq[$];
    int err_count = 0, checks_done = 0, cyc = 0;
    spd_top dut (.*);
    spd_ser_model m0 (.core_clk_i, .reset_i, .stall_i(stall), .tx_valid_i(tx_valid_o),
                      .tx_char_i(tx_char_o), .tx_ready_o(tx_ready_i));
    always #25 core_clk_i = !core_clk_i;
    function automatic logic [16:0] nx(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    // bare end words carry no data, so data is ignored there
    function automatic logic [31:0] msk(input spd_word_t x);
        return {22'h0, x.last, x.has_data, x.has_data ? x.data : 8'h00};
    endfunction
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge core_clk_i)
    begin
        lf <= nx(lf);
        net_out_ready_i <= lf[2] & !hold;
        stall <= lf[7] & lf[9];
        cyc <= cyc + 1;
        if (!reset_i && net_out_valid_o && net_out_ready_i)
            oq.push_back(net_out_word_o);
        if (cyc == 6000)
        begin
            err_count = err_count + 1;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    // waits at the falling edge so combinational readies have settled
    task automatic hs(input int k);
        int n = 0;
        logic ok;
        do
        begin
            @(negedge core_clk_i);
            ok = (k == 0) ? wb_ack_o : (k == 1) ? rx_ready_o : net_in_ready_o;
            rd = wb_dat_o;
            @(posedge core_clk_i);
            n++;
        end
        while (ok !== 1'b1 && n < 100);
        if (ok !== 1'b1)
            chk("handshake", 1, 0);
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        rx_valid_i <= 1'b0;
        net_in_valid_i <= 1'b0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        hs(0);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rx(input logic m, input logic [7:0] c, input logic [1:0] e);
        rx_valid_i <= 1'b1;
        rx_char_i <= {m, c};
        hs(1);
        if (e != 2'b00)
            ex.push_back({e, c});
    endtask
    task automatic nin(input logic l, input logic [7:0] c);
        rx_valid_i <= 1'b0;
        net_in_valid_i <= 1'b1;
        net_in_word_i <= {l, 1'b1, c};
        hs(2);
    endtask
    task automatic fin(input string nm);
        rx_valid_i <= 1'b0;
        net_in_valid_i <= 1'b0;
        repeat (30) @(posedge core_clk_i);
        chk("rx count", ex.size(), oq.size());
        foreach (ex[k])
            chk("rx word", msk(ex[k]), (k < oq.size()) ? msk(oq[k]) : 32'hFFFF);
        chk("tx count", tq.size(), m0.got.size());
        foreach (tq[k])
            chk("tx char", tq[k], (k < m0.got.size()) ? m0.got[k] : 9'h1FF);
        ex = {};
        oq = {};
        tq = {};
        m0.got = {};
        $display("test %s done", nm);
    endtask
    logic [7:0] ra[4] = '{ADR_FORMAT, ADR_TERM_LO, ADR_THRESH, 8'h3C};
    logic [31:0] rv[4] = '{32'h1, 32'hA, 32'h3FC, 32'h0};
    initial
    begin
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        foreach (ra[k])
        begin
            wb(1'b0, ra[k], 32'h0);
            chk("reg reset", rv[k], rd);
        end
        wb(1'b1, ADR_CTRL, 32'h2);
        wb(1'b1, ADR_FORMAT, 32'h2);
        wb(1'b1, ADR_TERM_LO, 32'h0A0D);
        hold <= 1'b1;
        @(posedge core_clk_i);
        rx(1'b0, {2'b01, lf[5:0]}, 2'b01);
        rx(1'b0, {2'b01, lf[8:3]}, 2'b01);
        rx_valid_i <= 1'b0;
        @(negedge core_clk_i);
        chk("rx full", 0, rx_ready_o);
        hold <= 1'b0;
        @(posedge core_clk_i);
        rx(1'b0, 8'h0D, 2'b01);
        rx(1'b0, 8'h0A, 2'b11);
        wb(1'b1, ADR_FORMAT, 32'h0102);
        rx(1'b0, 8'h0D, 2'b01);
        rx(1'b0, 8'h0A, 2'b01);
        rx(1'b0, lf[7:0], 2'b11);
        nin(1'b1, 8'h45);
        tq.push_back(9'h045);
        fin("send");
        wb(1'b1, ADR_CTRL, 32'h3);
        wb(1'b1, ADR_FORMAT, 32'h2);
        rx(1'b0, 8'h42, 2'b01);
        rx(1'b0, 8'h0D, 2'b01);
        rx(1'b0, 8'h0D, 2'b00);
        rx(1'b0, 8'h0A, 2'b10);
        nin(1'b1, 8'h44);
        tq = '{9'h044, 9'h00D, 9'h00A};
        fin("cut");
        wb(1'b1, ADR_CTRL, 32'h14);
        chk("marker cfg", 3'b111, {cfg_marker_mode_o, cfg_parity_off_o, cfg_seven_bit_o});
        rx(1'b1, 8'h41, 2'b01);
        rx(1'b0, 8'h43, 2'b01);
        ex.push_back(10'h200);
        rx(1'b1, 8'h48, 2'b01);
        wb(1'b1, ADR_THRESH, 32'h3);
        net_in_end_held_i <= 1'b0;
        net_in_level_i <= 10'h002;
        @(negedge core_clk_i);
        chk("tx held", 0, net_in_ready_o);
        @(posedge core_clk_i);
        net_in_level_i <= 10'h003;
        @(negedge core_clk_i);
        chk("tx released", 1, net_in_ready_o);
        @(posedge core_clk_i);
        nin(1'b0, 8'hC6);
        nin(1'b1, 8'h47);
        nin(1'b0, 8'h49);
        tq = '{9'h146, 9'h047, 9'h149};
        fin("marker");
        wb(1'b0, ADR_STATUS, 32'h0);
        chk("status", 32'h00040002, rd);
        give_verdict();
    end
endmodule // tb
